//--- logic/sipc_pkg.sv
// Purpose: Constants shared by the ingress priority configuration block
// Assumes: Register numbers are word addresses on the switch register port
// Notes: Every offset, field position, reset value and latency lives here
package sipc_pkg;
    // Register numbers
    localparam logic [15:0] SIPC_VLAN_CMD_STATUS = 16'h1810;
    localparam logic [15:0] SIPC_PRIO_TABLE_COMMAND = 16'h1811;
    localparam logic [15:0] SIPC_PRIO_TABLE_WRITE_DATA = 16'h1812;
    localparam logic [15:0] SIPC_PRIO_TABLE_READ_DATA = 16'h1813;
    localparam logic [15:0] SIPC_PRIO_TABLE_CMD_STATUS = 16'h1814;
    localparam logic [15:0] SIPC_GLOBAL_INGRESS_CONFIG = 16'h1840;

    // Widths
    localparam int SIPC_ADDR_W = 16;
    localparam int SIPC_DATA_W = 32;
    localparam int SIPC_INDEX_W = 6;
    localparam int SIPC_PRIO_W = 3;
    localparam int SIPC_TABLE_DEPTH = 64;
    localparam int SIPC_CFG_W = 16;

    // Status fields
    localparam int SIPC_PENDING_BIT = 0;

    // Table command fields
    localparam int SIPC_CMD_RNW_BIT = 7;
    localparam int SIPC_CMD_INDEX_MSB = 5;
    localparam int SIPC_CMD_INDEX_LSB = 0;
    localparam logic [7:0] SIPC_CMD_MASK = 8'hbf;
    localparam logic [7:0] SIPC_CMD_RESET = 8'h00;
    localparam logic [2:0] SIPC_PRIO_RESET = 3'h0;

    // Global ingress configuration fields
    localparam int SIPC_CFG_VLAN_ID_OVERRIDE = 15;
    localparam int SIPC_CFG_USE_TAG = 14;
    localparam int SIPC_CFG_MONITOR_ECHO = 13;
    localparam int SIPC_CFG_IGMP_MAP_MSB = 12;
    localparam int SIPC_CFG_IGMP_MAP_LSB = 10;
    localparam int SIPC_CFG_USE_IP = 9;
    localparam int SIPC_CFG_SPARE = 8;
    localparam int SIPC_CFG_IGMP_EN = 7;
    localparam int SIPC_CFG_COUNTER_TEST = 6;
    localparam int SIPC_CFG_DA_PRIO = 5;
    localparam int SIPC_CFG_FILTER_MCAST = 4;
    localparam int SIPC_CFG_DROP_UNKNOWN = 3;
    localparam int SIPC_CFG_USE_PRECEDENCE = 2;
    localparam int SIPC_CFG_TAG_OVER_IP = 1;
    localparam int SIPC_CFG_VLAN_ENABLE = 0;
    localparam logic [15:0] SIPC_CFG_RESET = 16'h0006;

    // Counter reload values
    localparam logic [31:0] SIPC_COUNTER_TEST_VALUE = 32'h7fff_fffc;
    localparam logic [31:0] SIPC_COUNTER_CLEAR_VALUE = 32'h0000_0000;

    // Table access pipeline stages; done follows three clock cycles after start
    localparam int SIPC_TABLE_LATENCY = 2;
endpackage

//--- logic/sipc_prio_table.sv
// Purpose: 64-entry ToS/CS to receive priority table with one host access port
// Assumes: One access at a time; i_start only while idle
// Notes: Entries hold no reset value; a separate lookup port feeds the datapath
`timescale 1ns/1ps
module sipc_prio_table
    import sipc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    input wire logic i_start,
    input wire logic i_read_not_write,
    input wire logic [sipc_pkg::SIPC_INDEX_W-1:0] i_index,
    input wire logic [sipc_pkg::SIPC_PRIO_W-1:0] i_wdata,
    output logic [sipc_pkg::SIPC_PRIO_W-1:0] o_rdata,
    output logic o_done,
    input wire logic [sipc_pkg::SIPC_INDEX_W-1:0] i_lookup_index,
    output logic [sipc_pkg::SIPC_PRIO_W-1:0] o_lookup_prio
);
    logic [SIPC_PRIO_W-1:0] table_mem [SIPC_TABLE_DEPTH];
    logic [SIPC_TABLE_LATENCY-1:0] stage;
    logic rnw_hold;
    logic [SIPC_INDEX_W-1:0] index_hold;
    logic [SIPC_PRIO_W-1:0] wdata_hold;
    wire logic last_stage;

    assign last_stage = stage[SIPC_TABLE_LATENCY-1];

    // Access pipeline: capture command, act in last stage
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            stage <= '0;
            rnw_hold <= 1'b0;
            index_hold <= '0;
            wdata_hold <= '0;
        end else begin
            stage <= {stage[SIPC_TABLE_LATENCY-2:0], i_start};
            if (i_start) begin
                rnw_hold <= i_read_not_write;
                index_hold <= i_index;
                wdata_hold <= i_wdata;
            end
        end
    end

    // Storage has no reset, software must fill it
    always_ff @(posedge i_core_clk) begin
        if (last_stage && !rnw_hold) begin
            table_mem[index_hold] <= wdata_hold; // R3 R4 R8
        end
    end

    // Read result and done pulse
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_rdata <= SIPC_PRIO_RESET;
            o_done <= 1'b0;
            o_lookup_prio <= SIPC_PRIO_RESET;
        end else begin
            o_done <= last_stage;
            if (last_stage && rnw_hold) begin
                o_rdata <= table_mem[index_hold]; // R3 R6
            end
            o_lookup_prio <= table_mem[i_lookup_index];
        end
    end

    a_done_latency: assert property ( // R6
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_start |-> ##3 o_done)
        else $error("table done not three cycles after start");
endmodule

//--- logic/sipc_regs.sv
// Purpose: Host registers for VLAN command status, ToS/CS priority table and
//          global ingress configuration of the switch engine
// Assumes: Single core clock; register port strobes are one-cycle pulses
// Notes: Read data returns one cycle after the read strobe
// Notes on behaviour
// R1 - VLAN pending flag bit 0 set while a VLAN table access runs.
// R2 - Writing the table command register launches exactly one table access; here a write while table pending is set is dropped.
// R3 - Command bit 7 picks direction: one reads, zero writes the entry.
// R4 - Command bits 5..0 select which of 64 table entries is accessed.
// R5 - Software loads write data before a write command, then polls pending.
// R6 - Read result is in read-data register before pending clears.
// R7 - Table status bit 0 is set during an access, clears itself after.
// R8 - Entries hold 3-bit priorities, not reset; software fills them first.
// R9 - Bit 15 substitutes port default VLAN id for received VLAN id.
// R10 - Bit 14 allows tag priority as transmit queue source.
// R11 - Bit 13 allows monitor packets back to their source port.
// R12 - Bit 7 enables IGMP snooping toward port map in bits 12..10.
// R13 - Bit 9 allows IPv4 TOS or IPv6 class as queue source.
// R14 - Bit 6 makes read-cleared counters reload the fixed test value.
// R15 - Bit 5 lets address-table priority choose transmit queue.
// R16 - Bit 4 drops unknown multicast destinations, never broadcasts.
// R17 - Bit 3 drops unknown unicast destinations.
// R18 - Bit 2 picks TOS precedence (set) or mapping table for IPv4.
// R19 - Bit 1 prefers tag priority over IP field when tag use enabled.
// R20 - Bit 0 enables VLAN ingress rule checking.
// R21 - Pending flag is set in the cycle after the command write.
`timescale 1ns/1ps
module sipc_regs
    import sipc_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rstn,
    // Register port
    input wire logic [sipc_pkg::SIPC_ADDR_W-1:0] i_reg_addr,
    input wire logic i_reg_wr,
    input wire logic i_reg_rd,
    input wire logic [sipc_pkg::SIPC_DATA_W-1:0] i_reg_wdata,
    output logic [sipc_pkg::SIPC_DATA_W-1:0] o_reg_rdata,
    output logic o_reg_rvalid,
    // VLAN table engine progress
    input wire logic i_vlan_op_start,
    input wire logic i_vlan_op_done,
    // Datapath lookup of the priority table
    input wire logic [sipc_pkg::SIPC_INDEX_W-1:0] i_lookup_index,
    output logic [sipc_pkg::SIPC_PRIO_W-1:0] o_lookup_prio,
    // Configuration toward the forwarding logic
    output logic o_vlan_id_override,
    output logic o_use_tag_prio,
    output logic o_allow_monitor_echo,
    output logic [2:0] o_igmp_port_map,
    output logic o_igmp_snoop_en,
    output logic o_use_ip_prio,
    output logic o_counter_test_mode,
    output logic [sipc_pkg::SIPC_DATA_W-1:0] o_counter_read_reload,
    output logic o_da_prio_en,
    output logic o_filter_unknown_mcast,
    output logic o_drop_unknown_ucast,
    output logic o_use_precedence,
    output logic o_ip_prio_from_table,
    output logic o_tag_over_ip_priority,
    output logic o_tag_prio_first,
    output logic o_vlan_enable
);
    logic vlan_pending;
    logic tbl_pending;
    logic [7:0] tbl_command;
    logic [SIPC_PRIO_W-1:0] tbl_write_data;
    logic [SIPC_PRIO_W-1:0] tbl_read_data;
    logic [SIPC_CFG_W-1:0] cfg;
    logic [SIPC_DATA_W-1:0] next_rdata;
    wire logic [SIPC_PRIO_W-1:0] table_rdata;
    wire logic table_done;
    wire logic hit_cmd;
    wire logic hit_wdata;
    wire logic hit_cfg;
    wire logic cmd_accept;
    wire logic [7:0] cmd_value;

    // Address decode for writes
    assign hit_cmd = i_reg_wr && (i_reg_addr == SIPC_PRIO_TABLE_COMMAND);
    assign hit_wdata = i_reg_wr && (i_reg_addr == SIPC_PRIO_TABLE_WRITE_DATA);
    assign hit_cfg = i_reg_wr && (i_reg_addr == SIPC_GLOBAL_INGRESS_CONFIG);
    assign cmd_value = i_reg_wdata[7:0] & SIPC_CMD_MASK;
    // A command arriving mid-access is dropped, the running one completes
    assign cmd_accept = hit_cmd && !tbl_pending; // R2

    // VLAN pending: start wins over a done in the same cycle
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            vlan_pending <= 1'b0;
        end else if (i_vlan_op_start) begin
            vlan_pending <= 1'b1; // R1
        end else if (i_vlan_op_done) begin
            vlan_pending <= 1'b0; // R1
        end
    end

    // Table command and write data registers
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tbl_command <= SIPC_CMD_RESET;
            tbl_write_data <= SIPC_PRIO_RESET;
        end else begin
            if (cmd_accept) begin
                tbl_command <= cmd_value; // R3 R4
            end
            if (hit_wdata) begin
                tbl_write_data <= i_reg_wdata[SIPC_PRIO_W-1:0]; // R5 R8
            end
        end
    end

    // Table pending: set the cycle after the command write, cleared on done
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tbl_pending <= 1'b0;
        end else if (cmd_accept) begin
            tbl_pending <= 1'b1; // R7 R21
        end else if (table_done) begin
            tbl_pending <= 1'b0; // R7
        end
    end

    // Read result captured with done, so it is stable when pending drops
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            tbl_read_data <= SIPC_PRIO_RESET;
        end else if (table_done && tbl_command[SIPC_CMD_RNW_BIT]) begin
            tbl_read_data <= table_rdata; // R6
        end
    end

    // Global ingress configuration word, spare bit 8 kept as storage
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cfg <= SIPC_CFG_RESET; // R18 R19
        end else if (hit_cfg) begin
            cfg <= i_reg_wdata[SIPC_CFG_W-1:0];
        end
    end

    // Table storage and access sequencing
    sipc_prio_table u_table (
        .i_core_clk(i_core_clk),
        .i_rstn(i_rstn),
        .i_start(cmd_accept), // R2
        .i_read_not_write(cmd_value[SIPC_CMD_RNW_BIT]), // R3
        .i_index(cmd_value[SIPC_CMD_INDEX_MSB:SIPC_CMD_INDEX_LSB]), // R4
        .i_wdata(tbl_write_data), // R5
        .o_rdata(table_rdata),
        .o_done(table_done),
        .i_lookup_index(i_lookup_index),
        .o_lookup_prio(o_lookup_prio)
    );

    // Read-back mux, unmapped numbers read as zero
    always_comb begin
        next_rdata = '0;
        if (i_reg_addr == SIPC_VLAN_CMD_STATUS) begin
            next_rdata[SIPC_PENDING_BIT] = vlan_pending; // R1
        end else if (i_reg_addr == SIPC_PRIO_TABLE_COMMAND) begin
            next_rdata[7:0] = tbl_command;
        end else if (i_reg_addr == SIPC_PRIO_TABLE_WRITE_DATA) begin
            next_rdata[SIPC_PRIO_W-1:0] = tbl_write_data;
        end else if (i_reg_addr == SIPC_PRIO_TABLE_READ_DATA) begin
            next_rdata[SIPC_PRIO_W-1:0] = tbl_read_data; // R6
        end else if (i_reg_addr == SIPC_PRIO_TABLE_CMD_STATUS) begin
            next_rdata[SIPC_PENDING_BIT] = tbl_pending; // R7
        end else if (i_reg_addr == SIPC_GLOBAL_INGRESS_CONFIG) begin
            next_rdata[SIPC_CFG_W-1:0] = cfg;
        end
    end

    // Registered read answer
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_reg_rdata <= '0;
            o_reg_rvalid <= 1'b0;
        end else begin
            o_reg_rvalid <= i_reg_rd;
            if (i_reg_rd) begin
                o_reg_rdata <= next_rdata;
            end
        end
    end

    // Counter reload value seen by read-cleared statistics counters
    always_ff @(posedge i_core_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_counter_read_reload <= SIPC_COUNTER_CLEAR_VALUE;
        end else if (cfg[SIPC_CFG_COUNTER_TEST]) begin
            o_counter_read_reload <= SIPC_COUNTER_TEST_VALUE; // R14
        end else begin
            o_counter_read_reload <= SIPC_COUNTER_CLEAR_VALUE; // R14
        end
    end

    // Configuration fields toward the forwarding logic
    assign o_vlan_id_override = cfg[SIPC_CFG_VLAN_ID_OVERRIDE]; // R9
    assign o_use_tag_prio = cfg[SIPC_CFG_USE_TAG]; // R10
    assign o_allow_monitor_echo = cfg[SIPC_CFG_MONITOR_ECHO]; // R11
    assign o_igmp_port_map = cfg[SIPC_CFG_IGMP_MAP_MSB:SIPC_CFG_IGMP_MAP_LSB]; // R12
    assign o_igmp_snoop_en = cfg[SIPC_CFG_IGMP_EN]; // R12
    assign o_use_ip_prio = cfg[SIPC_CFG_USE_IP]; // R13
    assign o_counter_test_mode = cfg[SIPC_CFG_COUNTER_TEST]; // R14
    assign o_da_prio_en = cfg[SIPC_CFG_DA_PRIO]; // R15
    assign o_filter_unknown_mcast = cfg[SIPC_CFG_FILTER_MCAST]; // R16
    assign o_drop_unknown_ucast = cfg[SIPC_CFG_DROP_UNKNOWN]; // R17
    assign o_use_precedence = cfg[SIPC_CFG_USE_PRECEDENCE]; // R18
    assign o_tag_over_ip_priority = cfg[SIPC_CFG_TAG_OVER_IP]; // R19
    assign o_vlan_enable = cfg[SIPC_CFG_VLAN_ENABLE]; // R20

    // Derived priority source selection
    assign o_ip_prio_from_table = cfg[SIPC_CFG_USE_IP] && !cfg[SIPC_CFG_USE_PRECEDENCE]; // R18
    assign o_tag_prio_first = cfg[SIPC_CFG_USE_TAG] && cfg[SIPC_CFG_TAG_OVER_IP]; // R19

    // Checks on status, command and configuration behaviour
    a_vlan_set: assert property ( // R1
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_vlan_op_start |=> vlan_pending)
        else $error("VLAN pending not set after start");

    a_vlan_clear: assert property ( // R1
        @(posedge i_core_clk) disable iff (!i_rstn)
        vlan_pending && i_vlan_op_done && !i_vlan_op_start |=> !vlan_pending)
        else $error("VLAN pending not cleared after done");

    a_pend_next: assert property ( // R21
        @(posedge i_core_clk) disable iff (!i_rstn)
        hit_cmd && !tbl_pending |=> tbl_pending)
        else $error("table pending not set the cycle after command");

    a_pend_bounded: assert property ( // R7
        @(posedge i_core_clk) disable iff (!i_rstn)
        $rose(tbl_pending) |-> tbl_pending[*3] ##1 !tbl_pending)
        else $error("table pending did not last exactly three cycles");

    a_busy_ignore: assert property ( // R2
        @(posedge i_core_clk) disable iff (!i_rstn)
        hit_cmd && tbl_pending |=> $stable(tbl_command))
        else $error("command changed during a running access");

    a_cmd_fields: assert property ( // R4
        @(posedge i_core_clk) disable iff (!i_rstn)
        cmd_accept |=> tbl_command == ($past(i_reg_wdata[7:0]) & 8'hbf))
        else $error("command register does not hold written fields");

    a_read_ready: assert property ( // R6
        @(posedge i_core_clk) disable iff (!i_rstn)
        $fell(tbl_pending) && tbl_command[SIPC_CMD_RNW_BIT]
            |-> tbl_read_data == $past(table_rdata))
        else $error("read data not in place when pending cleared");

    a_write_keeps: assert property ( // R3
        @(posedge i_core_clk) disable iff (!i_rstn)
        $fell(tbl_pending) && !tbl_command[SIPC_CMD_RNW_BIT] |-> $stable(tbl_read_data))
        else $error("write access disturbed the read data register");

    a_cfg_vlan: assert property ( // R20
        @(posedge i_core_clk) disable iff (!i_rstn)
        hit_cfg |=> o_vlan_enable == $past(i_reg_wdata[0]) && o_vlan_id_override
            == $past(i_reg_wdata[15]))
        else $error("configuration write not reflected on VLAN outputs");

    a_counter_test: assert property ( // R14
        @(posedge i_core_clk) disable iff (!i_rstn)
        hit_cfg && i_reg_wdata[6] |=> ##1 o_counter_read_reload == 32'h7fff_fffc)
        else $error("counter test reload value missing");

    a_rd_answer: assert property ( // R7
        @(posedge i_core_clk) disable iff (!i_rstn)
        i_reg_rd && i_reg_addr == SIPC_PRIO_TABLE_CMD_STATUS
            |=> o_reg_rvalid && o_reg_rdata == {31'h0, $past(tbl_pending)})
        else $error("status read returned wrong value");
endmodule

//--- testbench/tb_top.sv
// Purpose: Self-checking bench for the ingress priority configuration registers
// Assumes: Strobes are one-cycle pulses; read data lands one cycle after the strobe
// Notes: Random values come from a fixed LFSR seed so every run repeats
`timescale 1ns/1ps
module tb_top;
    import sipc_pkg::*;
    logic i_core_clk = 1'b0;
    logic i_rstn = 1'b0;
    logic [15:0] i_reg_addr = 16'h0000;
    logic i_reg_wr = 1'b0;
    logic i_reg_rd = 1'b0;
    logic [31:0] i_reg_wdata = 32'h0000_0000;
    logic i_vlan_op_start = 1'b0;
    logic i_vlan_op_done = 1'b0;
    logic [5:0] i_lookup_index = 6'h00;
    logic [31:0] o_reg_rdata, o_counter_read_reload;
    logic [2:0] o_lookup_prio, o_igmp_port_map;
    logic o_reg_rvalid, o_vlan_id_override, o_use_tag_prio, o_allow_monitor_echo;
    logic o_igmp_snoop_en, o_use_ip_prio, o_counter_test_mode, o_da_prio_en;
    logic o_filter_unknown_mcast, o_drop_unknown_ucast, o_use_precedence;
    logic o_ip_prio_from_table, o_tag_over_ip_priority, o_tag_prio_first, o_vlan_enable;
    int miscompares = 0;
    int total_checks = 0;
    int n;
    logic [31:0] lfsr = 32'h0000_07c9;
    logic [31:0] rd_val, v;
    logic [2:0] model [64];
    logic [15:0] addr_list [6] = '{16'h1810, 16'h1811, 16'h1812, 16'h1813, 16'h1814, 16'h1840};
    logic [31:0] reset_list [6] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0000_0006};
    logic [16:0] cfg_seen;

    // Core clock, 8 ns period
    always #4 i_core_clk = ~i_core_clk;

    // Configuration outputs gathered in field order
    assign cfg_seen = {o_vlan_id_override, o_use_tag_prio, o_allow_monitor_echo,
        o_igmp_port_map, o_use_ip_prio, o_igmp_snoop_en, o_counter_test_mode, o_da_prio_en,
        o_filter_unknown_mcast, o_drop_unknown_ucast, o_use_precedence,
        o_ip_prio_from_table, o_tag_over_ip_priority, o_tag_prio_first, o_vlan_enable};

    sipc_regs u_sipc_regs (
        .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_reg_addr(i_reg_addr),
        .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd), .i_reg_wdata(i_reg_wdata),
        .o_reg_rdata(o_reg_rdata), .o_reg_rvalid(o_reg_rvalid),
        .i_vlan_op_start(i_vlan_op_start), .i_vlan_op_done(i_vlan_op_done),
        .i_lookup_index(i_lookup_index), .o_lookup_prio(o_lookup_prio),
        .o_vlan_id_override(o_vlan_id_override), .o_use_tag_prio(o_use_tag_prio),
        .o_allow_monitor_echo(o_allow_monitor_echo), .o_igmp_port_map(o_igmp_port_map),
        .o_igmp_snoop_en(o_igmp_snoop_en), .o_use_ip_prio(o_use_ip_prio),
        .o_counter_test_mode(o_counter_test_mode),
        .o_counter_read_reload(o_counter_read_reload), .o_da_prio_en(o_da_prio_en),
        .o_filter_unknown_mcast(o_filter_unknown_mcast),
        .o_drop_unknown_ucast(o_drop_unknown_ucast), .o_use_precedence(o_use_precedence),
        .o_ip_prio_from_table(o_ip_prio_from_table),
        .o_tag_over_ip_priority(o_tag_over_ip_priority),
        .o_tag_prio_first(o_tag_prio_first), .o_vlan_enable(o_vlan_enable)
    );

    // Next pseudo-random word
    function automatic logic [31:0] next_rand();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction

    // Expected configuration outputs for a written word
    function automatic logic [16:0] exp_cfg(input logic [15:0] c);
        return {c[15], c[14], c[13], c[12:10], c[9], c[7], c[6], c[5], c[4], c[3], c[2],
            c[9] & ~c[2], c[1], c[14] & c[1], c[0]};
    endfunction

    // Compare one result, count it, report a mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Counts, verdict and end of run
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, miscompares);
        if (miscompares == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // One write strobe; returns just after the taking edge
    task automatic reg_wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge i_core_clk);
        #1;
        i_reg_addr = a;
        i_reg_wdata = d;
        i_reg_wr = 1'b1;
        @(posedge i_core_clk);
        #1;
        i_reg_wr = 1'b0;
    endtask

    // One read strobe; data taken with the valid pulse
    task automatic reg_rd(input logic [15:0] a, output logic [31:0] d);
        @(posedge i_core_clk);
        #1;
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        @(posedge i_core_clk);
        #1;
        i_reg_rd = 1'b0;
        chk("rvalid", 32'h1, {31'h0, o_reg_rvalid});
        d = o_reg_rdata;
        // Valid stands one cycle only
        @(posedge i_core_clk);
        #1;
        chk("rvalid_drop", 32'h0, {31'h0, o_reg_rvalid});
    endtask

    // Back-to-back status reads until the pending flag drops, bounded
    task automatic poll_pending(input logic [15:0] a, output int cnt);
        logic busy;
        busy = 1'b1;
        cnt = 0;
        i_reg_addr = a;
        i_reg_rd = 1'b1;
        for (int k = 0; k < 16 && busy === 1'b1; k++) begin
            @(posedge i_core_clk);
            #1;
            busy = o_reg_rdata[0];
            if (busy === 1'b1) cnt++;
        end
        i_reg_rd = 1'b0;
        if (busy !== 1'b0) begin
            miscompares++;
            $display("mismatch pending_timeout expected 0 seen %b", busy);
            close_out();
        end
    endtask

    // Table access through the command register, then lookup port check
    task automatic table_op(input logic read_not_write, input logic [5:0] idx, input logic [2:0] prio);
        if (!read_not_write) begin
            reg_wr(SIPC_PRIO_TABLE_WRITE_DATA, {29'h0, prio});
            model[idx] = prio;
        end
        reg_wr(SIPC_PRIO_TABLE_COMMAND, {24'h0, read_not_write, 1'b0, idx});
        poll_pending(SIPC_PRIO_TABLE_CMD_STATUS, n);
        chk("table_pending_cycles", 32'h3, n);
        if (read_not_write) begin
            reg_rd(SIPC_PRIO_TABLE_READ_DATA, rd_val);
            chk("table_read_data", {29'h0, model[idx]}, rd_val);
        end
        i_lookup_index = idx;
        @(posedge i_core_clk);
        #1;
        chk("lookup_prio", {29'h0, model[idx]}, {29'h0, o_lookup_prio});
    endtask

    // VLAN engine progress pulses
    task automatic vlan_pulse(input logic s, input logic d);
        @(posedge i_core_clk);
        #1;
        i_vlan_op_start = s;
        i_vlan_op_done = d;
        @(posedge i_core_clk);
        #1;
        i_vlan_op_start = 1'b0;
        i_vlan_op_done = 1'b0;
    endtask

    // Hang guard
    initial begin
        repeat (50000) @(posedge i_core_clk);
        miscompares++;
        $display("mismatch run_timeout expected done seen running");
        close_out();
    end

    // Main sequence
    initial begin
        repeat (3) @(posedge i_core_clk);
        #1;
        i_rstn = 1'b1;
        for (int i = 0; i < 6; i++) begin
            reg_rd(addr_list[i], rd_val);
            chk("register_reset", reset_list[i], rd_val);
        end
        chk("cfg_reset", {15'h0, exp_cfg(16'h0006)}, {15'h0, cfg_seen});
        $display("test reset done");

        for (int i = 0; i < 14; i++) begin
            v = (i == 0) ? 32'hffff_ffff : (i == 1) ? 32'h0 : next_rand();
            reg_wr(SIPC_GLOBAL_INGRESS_CONFIG, v);
            chk("cfg_outputs", {15'h0, exp_cfg(v[15:0])}, {15'h0, cfg_seen});
            @(posedge i_core_clk);
            #1;
            chk("counter_reload", v[6] ? SIPC_COUNTER_TEST_VALUE : SIPC_COUNTER_CLEAR_VALUE,
                o_counter_read_reload);
            reg_rd(SIPC_GLOBAL_INGRESS_CONFIG, rd_val);
            chk("cfg_readback", {16'h0, v[15:0]}, rd_val);
        end
        $display("test config done");

        for (int i = 0; i < 64; i++) begin
            v = next_rand();
            table_op(1'b0, i[5:0], v[2:0]);
        end
        for (int i = 63; i >= 0; i--) table_op(1'b1, i[5:0], 3'h0);
        $display("test table done");

        // Command while pending is dropped; reserved command bits read zero
        reg_wr(SIPC_PRIO_TABLE_WRITE_DATA, {29'h1fff_ffff, ~model[9]});
        reg_wr(SIPC_PRIO_TABLE_COMMAND, 32'hffff_ffc5);
        reg_wr(SIPC_PRIO_TABLE_COMMAND, 32'h0000_0009);
        poll_pending(SIPC_PRIO_TABLE_CMD_STATUS, n);
        reg_rd(SIPC_PRIO_TABLE_COMMAND, rd_val);
        chk("command_readback", 32'h0000_0085, rd_val);
        reg_rd(SIPC_PRIO_TABLE_READ_DATA, rd_val);
        chk("refused_read_data", {29'h0, model[5]}, rd_val);
        reg_rd(SIPC_PRIO_TABLE_WRITE_DATA, rd_val);
        chk("write_data_readback", {29'h0, ~model[9]}, rd_val);
        i_lookup_index = 6'h09;
        @(posedge i_core_clk);
        #1;
        chk("refused_entry", {29'h0, model[9]}, {29'h0, o_lookup_prio});
        $display("test refused done");

        // Read-only and unmapped numbers
        reg_wr(SIPC_PRIO_TABLE_READ_DATA, 32'hffff_ffff);
        reg_rd(SIPC_PRIO_TABLE_READ_DATA, rd_val);
        chk("ro_read_data", {29'h0, model[5]}, rd_val);
        reg_wr(SIPC_PRIO_TABLE_CMD_STATUS, 32'hffff_ffff);
        reg_rd(SIPC_PRIO_TABLE_CMD_STATUS, rd_val);
        chk("ro_table_status", 32'h0, rd_val);
        reg_wr(SIPC_VLAN_CMD_STATUS, 32'hffff_ffff);
        reg_rd(SIPC_VLAN_CMD_STATUS, rd_val);
        chk("ro_vlan_status", 32'h0, rd_val);
        reg_rd(16'h1815, rd_val);
        chk("unmapped_read", 32'h0, rd_val);
        $display("test access done");

        // VLAN pending follows the engine pulses
        vlan_pulse(1'b1, 1'b0);
        reg_rd(SIPC_VLAN_CMD_STATUS, rd_val);
        chk("vlan_pending_set", 32'h1, rd_val);
        vlan_pulse(1'b0, 1'b1);
        reg_rd(SIPC_VLAN_CMD_STATUS, rd_val);
        chk("vlan_pending_clear", 32'h0, rd_val);
        vlan_pulse(1'b1, 1'b1);
        reg_rd(SIPC_VLAN_CMD_STATUS, rd_val);
        chk("vlan_pending_both", 32'h1, rd_val);
        vlan_pulse(1'b0, 1'b1);
        poll_pending(SIPC_VLAN_CMD_STATUS, n);
        chk("vlan_pending_end", 32'h0, n);
        $display("test vlan done");
        close_out();
    end
endmodule
